// *** common/hrdz_pkg.sv ***
// Constants and carrier types for the home return sequencer.
// Assumes a 25 MHz system clock and a 32-bit signed encoder position.
package hrdz_pkg;

    // Clock and input filter timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int FILT_UNIT_NS   = 1000;                        // One filter setting step
    localparam int FILT_UNIT_CYC  = (FILT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_CW        = 13;                          // Holds 255 steps of 25 cycles

    // Filtered input vector layout
    localparam int IN_START  = 0;
    localparam int IN_AUTO   = 1;
    localparam int IN_PT_LO  = 2;
    localparam int PT_W      = 8;
    localparam int IN_BCD_LO = 10;
    localparam int BCD_W     = 4;
    localparam int IN_DOG    = 14;
    localparam int FILT_N    = 15;

    // Home method codes, lowest digit of the method parameter
    localparam logic [3:0] METHOD_CRADLE = 4'h7;
    localparam logic [3:0] METHOD_ZFIRST = 4'h8;
    localparam logic [3:0] METHOD_FRONT  = 4'h9;

    // Widths
    localparam int POS_W = 32;
    localparam int SPD_W = 16;
    localparam int TC_W  = 16;

    // Sequencer states, Gray coded along the first Z-phase path
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FAST  = 3'h1,
        ST_LEAVE = 3'h3,
        ST_SEEKZ = 3'h2,
        ST_SHIFT = 3'h6,
        ST_LOAD  = 3'h7,
        ST_DONE  = 3'h5
    } hrdz_state_t;

    // Motion command handed to the speed loop
    typedef struct packed {
        logic             run;
        logic             fwd;      // 1: address increasing
        logic [SPD_W-1:0] speed;
        logic [TC_W-1:0]  accel_tc;
        logic [TC_W-1:0]  decel_tc;
    } hrdz_motion_t;

endpackage

// *** core/hrdz_home_seq.sv ***
// Home position return sequencer: dog cradle, first Z-phase and front end methods.
// Assumes encoder_pos and the parameters come from logic on clk_sys; the
// controller inputs, the dog and the Z-phase pin are asynchronous.
`timescale 1ns/1ps

module hrdz_home_seq (
    input  wire logic                               clk_sys,
    input  wire logic                               rst,
    input  wire logic                               home_start_in,
    input  wire logic                               auto_manual_select,
    input  wire logic [hrdz_pkg::PT_W-1:0]          point_table_select,
    input  wire logic [hrdz_pkg::BCD_W-1:0]         bcd_speed_select,
    input  wire logic                               dog_in,
    input  wire logic                               zphase_in,
    input  wire logic signed [hrdz_pkg::POS_W-1:0]  encoder_pos,
    input  wire logic [15:0]                        home_method_param,
    input  wire logic                               home_direction_param,
    input  wire logic [hrdz_pkg::SPD_W-1:0]         home_return_speed_param,
    input  wire logic [hrdz_pkg::SPD_W-1:0]         creep_speed_param,
    input  wire logic signed [hrdz_pkg::POS_W-1:0]  home_shift_distance_param,
    input  wire logic signed [hrdz_pkg::POS_W-1:0]  home_position_data_param,
    input  wire logic signed [hrdz_pkg::POS_W-1:0]  post_dog_distance_param,
    input  wire logic                               dog_polarity_param,
    input  wire logic [7:0]                         input_filter_time_param,
    input  wire logic [hrdz_pkg::TC_W-1:0]          pt1_accel_tc,
    input  wire logic [hrdz_pkg::TC_W-1:0]          pt1_decel_tc,
    output hrdz_pkg::hrdz_motion_t                  motion_cmd_q,
    output logic signed [hrdz_pkg::POS_W-1:0]       current_position_q,
    output logic                                    busy_q,
    output logic                                    home_done_q,
    output logic                                    home_error_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and filters

    logic [hrdz_pkg::FILT_N-1:0]      raw_in;
    logic [hrdz_pkg::FILT_N-1:0]      sync1_q;
    logic [hrdz_pkg::FILT_N-1:0]      sync2_q;
    logic [hrdz_pkg::FILT_N-1:0]      filt_q;
    logic [hrdz_pkg::FILT_CW-1:0]     fcnt_q [hrdz_pkg::FILT_N];
    logic [hrdz_pkg::FILT_CW-1:0]     filt_lim;

    assign raw_in = {dog_in, bcd_speed_select, point_table_select,
                     auto_manual_select, home_start_in};
    // Filter length in cycles; zero means pass after the synchroniser
    assign filt_lim = hrdz_pkg::FILT_CW'(32'(input_filter_time_param) * hrdz_pkg::FILT_UNIT_CYC);

    // Two flops per asynchronous input before any logic looks at it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    // A change is accepted only once it has stood for the whole filter time
    for (genvar gi = 0; gi < hrdz_pkg::FILT_N; gi++) begin : g_filt
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                filt_q[gi] <= 1'b0;
                fcnt_q[gi] <= '0;
            end else if (sync2_q[gi] == filt_q[gi]) begin
                fcnt_q[gi] <= '0;
            end else if (fcnt_q[gi] >= filt_lim) begin
                filt_q[gi] <= sync2_q[gi];
                fcnt_q[gi] <= '0;
            end else begin
                fcnt_q[gi] <= fcnt_q[gi] + 1'b1;
            end
        end
    end

    // Z-phase is too short to filter; synchronise and take its rising edge
    logic zs1_q, zs2_q, zs3_q, z_evt;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            zs1_q <= 1'b0;
            zs2_q <= 1'b0;
            zs3_q <= 1'b0;
        end else begin
            zs1_q <= zphase_in;
            zs2_q <= zs1_q;
            zs3_q <= zs2_q;
        end
    end
    assign z_evt = zs2_q & ~zs3_q;

    ////////////////////////////////////////////////////////////////////////////
    // Decoded conditions

    logic       dog_act, start_prev_q, start_evt, manual_ok, method_ok;
    logic [3:0] method_dig;

    assign dog_act    = filt_q[hrdz_pkg::IN_DOG] ^ ~dog_polarity_param;
    assign method_dig = home_method_param[3:0];
    // Start refused unless the controller has set up manual home mode
    assign manual_ok  = filt_q[hrdz_pkg::IN_AUTO]
                      & ~|filt_q[hrdz_pkg::IN_PT_LO +: hrdz_pkg::PT_W]
                      & ~|filt_q[hrdz_pkg::IN_BCD_LO +: hrdz_pkg::BCD_W];
    assign method_ok  = (method_dig == hrdz_pkg::METHOD_CRADLE)
                      | (method_dig == hrdz_pkg::METHOD_ZFIRST)
                      | (method_dig == hrdz_pkg::METHOD_FRONT);
    assign start_evt  = filt_q[hrdz_pkg::IN_START] & ~start_prev_q;

    always_ff @(posedge clk_sys) begin
        if (rst) start_prev_q <= 1'b0;
        else     start_prev_q <= filt_q[hrdz_pkg::IN_START];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    hrdz_pkg::hrdz_state_t             state_q, state_d;
    logic [3:0]                        method_q;
    logic                              fwd_q, fwd_d;
    logic signed [hrdz_pkg::POS_W-1:0] target_q, target_d;
    logic signed [hrdz_pkg::POS_W-1:0] front_ofs, shift_ofs;
    logic                              reached, abort;

    // Offsets point the way the axis is moving when they are captured
    assign front_ofs = fwd_q ? (post_dog_distance_param + home_shift_distance_param)
                             : -(post_dog_distance_param + home_shift_distance_param);
    assign shift_ofs = fwd_q ? home_shift_distance_param : -home_shift_distance_param;
    assign reached   = fwd_q ? (encoder_pos >= target_q) : (encoder_pos <= target_q);
    // Dropping out of manual mode stops the run
    assign abort     = (state_q != hrdz_pkg::ST_IDLE) && (state_q != hrdz_pkg::ST_DONE)
                     && !filt_q[hrdz_pkg::IN_AUTO];

    always_comb begin
        state_d  = state_q;
        fwd_d    = fwd_q;
        target_d = target_q;
        case (state_q)
            hrdz_pkg::ST_IDLE, hrdz_pkg::ST_DONE: begin
                if (start_evt && manual_ok && method_ok) begin
                    state_d = hrdz_pkg::ST_FAST;
                    fwd_d   = ~home_direction_param;
                end
            end
            hrdz_pkg::ST_FAST: begin
                // Front end is the dog as sampled; slip of the synchroniser plus the whole filter time
                if (dog_act) begin
                    case (method_q)
                        hrdz_pkg::METHOD_ZFIRST: begin
                            state_d = hrdz_pkg::ST_LEAVE;
                            fwd_d   = ~fwd_q;
                        end
                        hrdz_pkg::METHOD_FRONT: begin
                            state_d  = hrdz_pkg::ST_SHIFT;
                            target_d = encoder_pos + front_ofs;
                        end
                        default: state_d = hrdz_pkg::ST_SEEKZ;
                    endcase
                end
            end
            hrdz_pkg::ST_LEAVE: begin
                if (!dog_act) state_d = hrdz_pkg::ST_SEEKZ;
            end
            hrdz_pkg::ST_SEEKZ: begin
                if (z_evt) begin
                    state_d  = hrdz_pkg::ST_SHIFT;
                    target_d = encoder_pos + shift_ofs;
                end
            end
            hrdz_pkg::ST_SHIFT: begin
                if (reached) state_d = hrdz_pkg::ST_LOAD;
            end
            hrdz_pkg::ST_LOAD: state_d = hrdz_pkg::ST_DONE;
            default: state_d = hrdz_pkg::ST_IDLE;
        endcase
        if (abort) state_d = hrdz_pkg::ST_IDLE;
    end

    // State, direction and target
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q  <= hrdz_pkg::ST_IDLE;
            fwd_q    <= 1'b0;
            target_q <= '0;
        end else begin
            state_q  <= state_d;
            fwd_q    <= fwd_d;
            target_q <= target_d;
        end
    end

    // Method is latched at start so a parameter edit cannot switch mid-run
    always_ff @(posedge clk_sys) begin
        if (rst) method_q <= '0;
        else if (state_d == hrdz_pkg::ST_FAST && state_q != hrdz_pkg::ST_FAST)
            method_q <= method_dig;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Motion command, built from the next state so it lines up with state_q

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            motion_cmd_q <= '0;
        end else begin
            motion_cmd_q.run      <= (state_d != hrdz_pkg::ST_IDLE)
                                   && (state_d != hrdz_pkg::ST_LOAD)
                                   && (state_d != hrdz_pkg::ST_DONE);
            motion_cmd_q.fwd      <= fwd_d;
            motion_cmd_q.speed    <= (state_d == hrdz_pkg::ST_FAST) ? home_return_speed_param
                                   : creep_speed_param;
            motion_cmd_q.accel_tc <= pt1_accel_tc;
            motion_cmd_q.decel_tc <= pt1_decel_tc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Current position and status

    logic signed [hrdz_pkg::POS_W-1:0] enc_prev_q;

    // Tracks encoder motion, then jumps to the home data on completion
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enc_prev_q         <= '0;
            current_position_q <= '0;
        end else begin
            enc_prev_q <= encoder_pos;
            if (state_q == hrdz_pkg::ST_LOAD)
                current_position_q <= home_position_data_param;
            else
                current_position_q <= current_position_q + (encoder_pos - enc_prev_q);
        end
    end

    // Done rises on the same edge as the load, so position is already valid
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_q       <= 1'b0;
            home_done_q  <= 1'b0;
            home_error_q <= 1'b0;
        end else begin
            busy_q       <= (state_d != hrdz_pkg::ST_IDLE) && (state_d != hrdz_pkg::ST_DONE);
            home_done_q  <= (state_d == hrdz_pkg::ST_DONE);
            if (start_evt && (state_q == hrdz_pkg::ST_IDLE || state_q == hrdz_pkg::ST_DONE))
                home_error_q <= ~(manual_ok & method_ok);
            else if (abort)
                home_error_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_fast_speed;
        busy_q && state_q == hrdz_pkg::ST_FAST |->
            motion_cmd_q.speed == home_return_speed_param && motion_cmd_q.run;
    endproperty
    a_fast_speed: assert property (p_fast_speed) else $error("fast speed wrong");
    property p_creep_speed;
        state_q inside {hrdz_pkg::ST_LEAVE, hrdz_pkg::ST_SEEKZ, hrdz_pkg::ST_SHIFT}
            |-> motion_cmd_q.speed == creep_speed_param;
    endproperty
    a_creep_speed: assert property (p_creep_speed) else $error("creep speed wrong");
    // Covers a restart from DONE as well as the first run
    property p_dir_start;
        state_q inside {hrdz_pkg::ST_IDLE, hrdz_pkg::ST_DONE} ##1 state_q == hrdz_pkg::ST_FAST
            |-> motion_cmd_q.fwd == !$past(home_direction_param);
    endproperty
    a_dir_start: assert property (p_dir_start) else $error("start direction wrong");
    property p_reverse;
        state_q == hrdz_pkg::ST_FAST ##1 state_q == hrdz_pkg::ST_LEAVE
            |-> motion_cmd_q.fwd != $past(motion_cmd_q.fwd);
    endproperty
    a_reverse: assert property (p_reverse) else $error("no reversal off dog");
    property p_cradle_z;
        state_q == hrdz_pkg::ST_SEEKZ && method_q == hrdz_pkg::METHOD_CRADLE && z_evt && !abort
            |=> state_q == hrdz_pkg::ST_SHIFT && target_q == $past(encoder_pos + shift_ofs);
    endproperty
    a_cradle_z: assert property (p_cradle_z) else $error("cradle Z not taken");
    property p_front_target;
        state_q == hrdz_pkg::ST_FAST && method_q == hrdz_pkg::METHOD_FRONT && dog_act && !abort
            |=> target_q == $past(encoder_pos) + $past(front_ofs);
    endproperty
    a_front_target: assert property (p_front_target) else $error("front target wrong");
    property p_front_no_z;
        method_q == hrdz_pkg::METHOD_FRONT |-> state_q != hrdz_pkg::ST_SEEKZ;
    endproperty
    a_front_no_z: assert property (p_front_no_z) else $error("front mode sought Z");
    property p_load;
        state_q == hrdz_pkg::ST_LOAD |=>
            current_position_q == $past(home_position_data_param) ##1 home_done_q;
    endproperty
    a_load: assert property (p_load) else $error("home data not loaded");
    // Done is registered from the next state, so it rises on the edge that leaves LOAD
    property p_done_after_load;
        $rose(home_done_q) |-> $past(state_q) == hrdz_pkg::ST_LOAD;
    endproperty
    a_done_after_load: assert property (p_done_after_load) else $error("early done");
    property p_tc;
        motion_cmd_q.run |-> motion_cmd_q.accel_tc == $past(pt1_accel_tc)
                          && motion_cmd_q.decel_tc == $past(pt1_decel_tc);
    endproperty
    a_tc: assert property (p_tc) else $error("time constants wrong");
    property p_refuse;
        state_q == hrdz_pkg::ST_IDLE && start_evt && !manual_ok |=> state_q == hrdz_pkg::ST_IDLE;
    endproperty
    a_refuse: assert property (p_refuse) else $error("start taken outside manual");

    c_cradle: cover property (method_q == hrdz_pkg::METHOD_CRADLE && $rose(home_done_q));
    c_zfirst: cover property (method_q == hrdz_pkg::METHOD_ZFIRST && $rose(home_done_q));
    c_front:  cover property (method_q == hrdz_pkg::METHOD_FRONT && $rose(home_done_q));
    c_abort:  cover property (abort);

endmodule // hrdz_home_seq

// *** dv/hrdz_axis_model.sv ***
// Axis model for the home return bench: integrates the motion command into an
// encoder count and derives the proximity dog and Z-phase pins from that count.
// Assumes the motion command is registered on clk_sys; the bench loads the start count.
`timescale 1ns/1ps

module hrdz_axis_model #(
    parameter int Z_PITCH = 64
) (
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    input  wire hrdz_pkg::hrdz_motion_t            motion_cmd,
    input  wire logic                              load_en,
    input  wire logic signed [hrdz_pkg::POS_W-1:0] load_pos,
    input  wire logic signed [hrdz_pkg::POS_W-1:0] dog_lo,
    input  wire logic signed [hrdz_pkg::POS_W-1:0] dog_hi,
    input  wire logic                              dog_polarity_param,
    output logic signed [hrdz_pkg::POS_W-1:0]      encoder_pos,
    output logic                                   dog_in,
    output logic                                   zphase_in
);
    logic signed [hrdz_pkg::POS_W-1:0] step;
    logic                              in_dog;
    int                                phase;

    ////////////////////////////////////////////////////////////////////////////
    // One speed unit per clock; no ramp, so a stop is abrupt
    assign step = {16'h0000, motion_cmd.speed};
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            encoder_pos <= '0;
        end else if (load_en) begin
            encoder_pos <= load_pos;
        end else if (motion_cmd.run) begin
            encoder_pos <= motion_cmd.fwd ? encoder_pos + step : encoder_pos - step;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Dog covers a closed range; Z is four counts wide so creep never skips it
    always_comb begin
        in_dog = (encoder_pos >= dog_lo) && (encoder_pos <= dog_hi);
        dog_in = dog_polarity_param ? in_dog : !in_dog;
        phase = ((encoder_pos % Z_PITCH) + Z_PITCH) % Z_PITCH;
        zphase_in = (phase < 4);
    end

endmodule // hrdz_axis_model

// *** dv/testbench.sv ***
// Self-checking bench for the home return sequencer, all three methods.
// Assumes hrdz_axis_model closes the position loop and a Z pitch of 64 counts.
`timescale 1ns/1ps

module testbench;
    localparam int FAST  = 4;
    localparam int CREEP = 1;
    logic                              clk_sys = 1'b0;
    logic                              rst = 1'b1;
    logic                              start = 1'b0;
    logic                              auto_sel = 1'b1;
    logic [7:0]                        pt_sel = 8'h00;
    logic [3:0]                        bcd_sel = 4'h0;
    logic [15:0]                       method = 16'h0000;
    logic                              dir = 1'b0;
    logic                              pol = 1'b1;
    logic [7:0]                        filt = 8'h00;
    logic signed [31:0]                shift = 32'h0, home_data = 32'h0, post = 32'h0;
    logic signed [31:0]                load_pos = 32'h0, dog_lo = 32'h0, dog_hi = 32'h0;
    logic                              load_en = 1'b0;
    logic [15:0]                       acc_tc = 16'h0000, dec_tc = 16'h0000;
    logic                              dog_in, zphase_in, busy, done, err;
    logic signed [31:0]                encoder_pos, cur_pos;
    hrdz_pkg::hrdz_motion_t            cmd;
    logic [31:0]                       rnd = 32'h2e9b62ea;
    int                                n_errors = 0;
    int                                cmp_count = 0;
    int                                cnt;
    logic signed [31:0]                exp_q [$];   // Expected current position per run

    hrdz_home_seq DUT (.clk_sys(clk_sys), .rst(rst), .home_start_in(start),
        .auto_manual_select(auto_sel), .point_table_select(pt_sel),
        .bcd_speed_select(bcd_sel), .dog_in(dog_in), .zphase_in(zphase_in),
        .encoder_pos(encoder_pos), .home_method_param(method), .home_direction_param(dir),
        .home_return_speed_param(16'(FAST)), .creep_speed_param(16'(CREEP)),
        .home_shift_distance_param(shift), .home_position_data_param(home_data),
        .post_dog_distance_param(post), .dog_polarity_param(pol),
        .input_filter_time_param(filt), .pt1_accel_tc(acc_tc), .pt1_decel_tc(dec_tc),
        .motion_cmd_q(cmd), .current_position_q(cur_pos), .busy_q(busy),
        .home_done_q(done), .home_error_q(err));

    hrdz_axis_model #(.Z_PITCH(64)) axis (.clk_sys(clk_sys), .rst(rst), .motion_cmd(cmd),
        .load_en(load_en), .load_pos(load_pos), .dog_lo(dog_lo), .dog_hi(dog_hi),
        .dog_polarity_param(pol), .encoder_pos(encoder_pos), .dog_in(dog_in),
        .zphase_in(zphase_in));

    ////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    always #20 clk_sys = ~clk_sys;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            n_errors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic test_done();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Fresh parameters, start count and dog, then a clean start edge
    task automatic start_pin(input logic [3:0] m, input logic d, input logic p,
                             input int lo, input int hi, input int p0);
        @(posedge clk_sys);
        rnd = lfsr(lfsr(rnd));
        method <= {12'h000, m};
        dir <= d;
        pol <= p;
        dog_lo <= lo;
        dog_hi <= hi;
        load_pos <= p0;
        load_en <= 1'b1;
        start <= 1'b0;
        shift <= {28'h0, rnd[3:0]};
        post <= 100 + rnd[9:4];
        home_data <= {{16{rnd[31]}}, rnd[31:16]};
        acc_tc <= rnd[15:0];
        dec_tc <= rnd[31:16] ^ 16'h5a5a;
        @(posedge clk_sys);
        load_en <= 1'b0;
        repeat (int'(filt) * 25 + 8) @(posedge clk_sys);
        start <= 1'b1;
        cnt = 0;
    endtask

    task automatic run(input logic [3:0] m, input logic d, input logic p,
                       input int lo, input int hi, input int p0);
        start_pin(m, d, p, lo, hi, p0);
        do begin @(posedge clk_sys); cnt++; end while (busy !== 1'b1 && cnt < 300);
        chk(cnt < 300, "start not taken");
        exp_q.push_back(home_data);
        chk(cmd.speed === FAST && cmd.fwd === !d, "fast phase");
        chk(cmd.accel_tc === acc_tc && cmd.decel_tc === dec_tc, "time constants");
    endtask

    // Wait for creep, then check direction and that the dog was reached
    task automatic creep(input logic fwd_exp, input int lo, input int hi);
        cnt = 0;
        do begin @(posedge clk_sys); cnt++; end while (cmd.speed !== CREEP && cnt < 600);
        chk(cnt < 600, "no creep phase");
        chk(cmd.fwd === fwd_exp, "creep direction");
        chk(encoder_pos >= lo - 4 * FAST && encoder_pos <= hi + 4 * FAST, "creep off dog");
    endtask

    task automatic finish(input int exp, input int tol);
        cnt = 0;
        do begin @(posedge clk_sys); cnt++; end while (done !== 1'b1 && cnt < 2000);
        chk(cnt < 2000, "no completion");
        chk(exp_q.size() != 0 && cur_pos === exp_q.pop_front(), "current position");
        chk(busy === 1'b0 && cmd.run === 1'b0 && err === 1'b0, "done flags");
        chk(encoder_pos >= exp && encoder_pos <= exp + tol, "home position");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [7:0]  bad_pt [3] = '{8'h10, 8'h00, 8'h00};
        logic [3:0]  bad_bcd [3] = '{4'h0, 4'h4, 4'h0};
        logic [3:0]  bad_m [3] = '{4'h9, 4'h7, 4'h5};
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        // Refused starts: table bit set, speed select set, unknown method
        for (int i = 0; i < 3; i++) begin
            pt_sel <= bad_pt[i];
            bcd_sel <= bad_bcd[i];
            start_pin(bad_m[i], 1'b0, 1'b1, 200, 300, 0);
            repeat (20) @(posedge clk_sys);
            chk(err === 1'b1 && busy === 1'b0 && cmd.run === 1'b0, "refused start");
        end
        pt_sel <= 8'h00;
        bcd_sel <= 4'h0;
        // Dog cradle, increasing, high active dog, first Z at 256
        run(4'h7, 1'b0, 1'b1, 200, 300, 0);
        chk(err === 1'b0, "error cleared by start");
        creep(1'b1, 200, 300);
        finish(256 + shift, 8);
        // First Z, decreasing, low active dog, leave upward, Z at 704
        run(4'h8, 1'b1, 1'b0, 600, 690, 1000);
        creep(1'b1, 600, 690);
        finish(704 + shift, 8);
        // Front end, Z ignored, dog sampling error allowed
        run(4'h9, 1'b0, 1'b1, 200, 300, 0);
        creep(1'b1, 200, 300);
        finish(200 + post + shift, 10 * FAST);
        // Filter delay on start and on the abort path
        filt <= 8'h01;
        run(4'h7, 1'b0, 1'b1, 2000, 2100, 0);
        chk(cnt > 25 && cnt <= 34, "start filter delay");
        auto_sel <= 1'b0;
        cnt = 0;
        do begin @(posedge clk_sys); cnt++; end while (busy !== 1'b0 && cnt < 300);
        chk(cnt > 25 && cnt <= 34 && err === 1'b1, "abort filter delay");
        auto_sel <= 1'b1;
        filt <= 8'h00;
        repeat (40) @(posedge clk_sys);
        test_done();
    end

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        $display("MISMATCH t=%0t timeout", $time);
        test_done();
    end

endmodule // testbench
